/* File: verilog/irs_pkg.sv */
`default_nettype none
package irs_pkg;
    // ----------------------------------------------------------------
    // Clocking and geometry
    // ----------------------------------------------------------------
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam int CORE_DIV = 4;
    localparam logic [7:0] KERNEL_LAST = 8'h9f;
    localparam logic [8:0] FRAME_LINES = 9'h1e0;
    localparam logic [9:0] LINE_CLOCKS = 10'h280;

    // ----------------------------------------------------------------
    // Line counter
    // ----------------------------------------------------------------
    localparam logic [11:0] LINE_START = 12'h001;
    localparam logic [11:0] LINE_START_SUB = 12'h002;
    localparam logic [11:0] LINE_STEP = 12'h001;
    localparam logic [11:0] LINE_STEP_SUB = 12'h002;

    // ----------------------------------------------------------------
    // Overhead and pulse timing, in core cycles per granularity step
    // ----------------------------------------------------------------
    localparam int PULSE_UNIT = 12;
    localparam int ROW_UNIT = 6;
    localparam logic [1:0] RESET_EXTRA = 2'h1;
    localparam logic [1:0] SAMPLE_EXTRA = 2'h2;
    localparam logic [1:0] FRM_EXTRA = 2'h2;

    // Pulse engine slots
    localparam int PI_DUAL = 0;
    localparam int PI_TRIPLE = 1;
    localparam int PI_XFER = 2;
    localparam int PI_SAMPLE = 3;

    typedef enum logic [2:0] {
        ST_FRM = 3'b001,
        ST_ROW = 3'b010,
        ST_KERN = 3'b100
    } irs_state_t;

    // Core cycles of 12*(overhead_granularity+1)+extra
    function automatic logic [7:0] irs_core_len(input logic [1:0] g, input logic [1:0] extra);
        irs_core_len = 8'(PULSE_UNIT * (int'(g) + 1) + int'(extra));
    endfunction : irs_core_len

    // Input clock cycles of 4*(12*(overhead_granularity+1)+extra)
    function automatic logic [7:0] irs_pulse_len(input logic [1:0] g, input logic [1:0] extra);
        irs_pulse_len = 8'(CORE_DIV * (PULSE_UNIT * (int'(g) + 1) + int'(extra)));
    endfunction : irs_pulse_len

    function automatic logic [7:0] irs_row_len(input logic [1:0] g);
        irs_row_len = 8'(ROW_UNIT * (int'(g) + 1));
    endfunction : irs_row_len
endpackage : irs_pkg
`default_nettype wire

/* File: verilog/irs_sequencer.sv */
// How it works
// - Core tick and core clock come from dividing the input clock by four.
// - Every frame readout starts with a frame overhead period, then lines.
// - Each line: row overhead, then 160 kernels of four pixels each.
// - Next frame integrates while the previous frame is still being read.
// - Master-mode input picks internal timing or pin-driven integration timing.
// - Master mode compares four 12-bit line settings against the line counter.
// - Reset-length match releases pixel reset and starts main integration.
// - Second/third line matches fire dual/triple slope resets of 4*(12*(g+1)+1) clocks.
// - Transfer line match starts frame transfer pulse and frame overhead.
// - Line counter loads 1 at reset and after each frame overhead.
// - Subsampling starts counter at 2, steps by 2; settings must be even.
// - Master windows high from their reset falling to pixel sample falling.
// - Pixel sample rises at transfer match, lasts 4*(12*(g+1)+2) clocks.
// - Frame valid is high while the array is read out.
// - Slave mode ignores line settings, integration pins become active-low inputs.
// - Pin1 low with pins 2,3 high resets; pins 2,3 give partial resets.
// - All three pins low together starts frame transfer at next line end.
// - Non-destructive read suppresses all pixel reset pulses.
// - In master mode frame valid falls after 480 line valid pulses.
// - Sequencer reset restores initial state and restarts clock division.
`timescale 1ns/1ps
`default_nettype none
module irs_sequencer
    import irs_pkg::*;
(
    // Clock and sequencer reset
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    // Settings
    input wire logic I_MASTER_MODE,
    input wire logic I_SUBSAMPLE,
    input wire logic I_NDR,
    input wire logic I_DUAL_SLOPE_EN,
    input wire logic I_TRIPLE_SLOPE_EN,
    input wire logic [1:0] I_OVERHEAD_GRANULARITY,
    input wire logic [11:0] I_RESET_LENGTH_LINES,
    input wire logic [11:0] I_SECOND_RESET_LINE,
    input wire logic [11:0] I_THIRD_RESET_LINE,
    input wire logic [11:0] I_TRANSFER_LINE,
    // Integration window pins
    input wire logic [2:0] I_INT_TIME,
    output logic [2:0] O_INT_TIME,
    output logic [2:0] O_INT_TIME_OE,
    // Timing outputs
    output logic O_CORE_CLK,
    output logic O_FRAME_VALID,
    output logic O_LINE_VALID,
    output logic O_FRAME_OVERHEAD,
    output logic O_ROW_OVERHEAD,
    output logic O_PIXEL_RESET,
    output logic O_DUAL_SLOPE_RESET,
    output logic O_TRIPLE_SLOPE_RESET,
    output logic O_FRAME_TRANSFER,
    output logic O_PIXEL_SAMPLE
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0] div;
    logic core_tick;
    irs_state_t state;
    logic [7:0] ph;
    logic [11:0] line_cnt;
    logic [11:0] step;
    logic [11:0] next_line;
    logic [8:0] lines_read;
    logic line_end;
    logic xfer_due;
    logic frm_start;
    logic frm_end;
    logic [7:0] frm_last;
    logic [7:0] row_last;
    logic hit_rst;
    logic hit_dual;
    logic hit_triple;
    logic [3:0] pstart;
    logic [3:0] pact;
    logic [3:0] pfall;
    logic [7:0] plen [4];
    logic [7:0] pcnt [4];
    logic [2:0] win;
    logic pix_rst;
    logic all_low;
    logic all_low_q;
    logic xfer_pend;

    function automatic logic line_hit(input logic [11:0] setting, input logic [11:0] nxt,
                                      input logic at_end, input logic master);
        line_hit = at_end && master && (nxt == setting);
    endfunction : line_hit

    // ----------------------------------------------------------------
    // Clock division
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
            div <= DIV_RESET;
        else
            div <= div + 2'h1;
    end

    assign core_tick = (div == DIV_LAST);

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
            O_CORE_CLK <= 1'b0;
        else
            O_CORE_CLK <= (div == 2'h1) || (div == 2'h2);
    end

    // ----------------------------------------------------------------
    // Readout sequencer
    // ----------------------------------------------------------------
    assign step = I_SUBSAMPLE ? LINE_STEP_SUB : LINE_STEP;
    assign next_line = line_cnt + step;
    assign frm_last = irs_core_len(I_OVERHEAD_GRANULARITY, FRM_EXTRA) - 8'h01;
    assign row_last = irs_row_len(I_OVERHEAD_GRANULARITY) - 8'h01;
    assign line_end = core_tick && (state == ST_KERN) && (ph == KERNEL_LAST);
    assign xfer_due = I_MASTER_MODE ? (next_line == I_TRANSFER_LINE) : xfer_pend;
    assign frm_start = line_end && xfer_due;
    assign frm_end = core_tick && (state == ST_FRM) && (ph == frm_last);

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            state <= ST_ROW;
            ph <= 8'h00;
            line_cnt <= I_SUBSAMPLE ? LINE_START_SUB : LINE_START;
            lines_read <= 9'h000;
            O_FRAME_VALID <= 1'b0;
            O_LINE_VALID <= 1'b0;
        end
        else if (core_tick)
        begin
            case (state)
                ST_FRM:
                begin
                    if (ph == frm_last)
                    begin
                        state <= ST_ROW;
                        ph <= 8'h00;
                        line_cnt <= I_SUBSAMPLE ? LINE_START_SUB : LINE_START;
                        lines_read <= 9'h000;
                        O_FRAME_VALID <= 1'b1;
                    end
                    else
                        ph <= ph + 8'h01;
                end
                ST_ROW:
                begin
                    if (ph == row_last)
                    begin
                        state <= ST_KERN;
                        ph <= 8'h00;
                        O_LINE_VALID <= 1'b1;
                    end
                    else
                        ph <= ph + 8'h01;
                end
                ST_KERN:
                begin
                    if (ph == KERNEL_LAST)
                    begin
                        ph <= 8'h00;
                        O_LINE_VALID <= 1'b0;
                        line_cnt <= next_line;
                        lines_read <= lines_read + 9'h001;
                        state <= xfer_due ? ST_FRM : ST_ROW;
                        if (xfer_due)
                            O_FRAME_VALID <= 1'b0;
                        else if (I_MASTER_MODE && (lines_read + 9'h001 == FRAME_LINES))
                            O_FRAME_VALID <= 1'b0;
                    end
                    else
                        ph <= ph + 8'h01;
                end
                default:
                begin
                    state <= ST_ROW;
                    ph <= 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Integration events and pulse engines
    // ----------------------------------------------------------------
    assign hit_rst = line_hit(I_RESET_LENGTH_LINES, next_line, line_end, I_MASTER_MODE);
    assign hit_dual = line_hit(I_SECOND_RESET_LINE, next_line, line_end, I_MASTER_MODE);
    assign hit_triple = line_hit(I_THIRD_RESET_LINE, next_line, line_end, I_MASTER_MODE);

    assign pstart[PI_DUAL] = hit_dual && I_DUAL_SLOPE_EN;
    assign pstart[PI_TRIPLE] = hit_triple && I_TRIPLE_SLOPE_EN;
    assign pstart[PI_XFER] = frm_start;
    assign pstart[PI_SAMPLE] = frm_start;
    assign plen[PI_DUAL] = irs_pulse_len(I_OVERHEAD_GRANULARITY, RESET_EXTRA);
    assign plen[PI_TRIPLE] = irs_pulse_len(I_OVERHEAD_GRANULARITY, RESET_EXTRA);
    assign plen[PI_XFER] = irs_pulse_len(I_OVERHEAD_GRANULARITY, RESET_EXTRA);
    assign plen[PI_SAMPLE] = irs_pulse_len(I_OVERHEAD_GRANULARITY, SAMPLE_EXTRA);

    for (genvar gi = 0; gi < 4; gi++)
    begin : g_pulse
        always_ff @(posedge I_REF_CLK)
        begin
            if (I_SRST)
                pcnt[gi] <= 8'h00;
            else if (pstart[gi])
                pcnt[gi] <= plen[gi];
            else if (pcnt[gi] != 8'h00)
                pcnt[gi] <= pcnt[gi] - 8'h01;
        end
        assign pact[gi] = (pcnt[gi] != 8'h00);
        assign pfall[gi] = (pcnt[gi] == 8'h01);
    end

    // Pixel reset level; the next frame's reset runs during readout
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
            pix_rst <= 1'b1;
        else if (!I_MASTER_MODE)
            pix_rst <= !I_INT_TIME[0] && I_INT_TIME[1] && I_INT_TIME[2];
        else if (frm_end)
            pix_rst <= 1'b1;
        else if (hit_rst)
            pix_rst <= 1'b0;
    end

    // Master-mode integration windows; a start wins over a same-cycle end
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST || !I_MASTER_MODE)
            win <= 3'h0;
        else
        begin
            if (pfall[PI_SAMPLE])
                win <= 3'h0;
            if (hit_rst)
                win[0] <= 1'b1;
            if (pfall[PI_DUAL])
                win[1] <= 1'b1;
            if (pfall[PI_TRIPLE])
                win[2] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Slave-mode frame transfer request
    // ----------------------------------------------------------------
    assign all_low = (I_INT_TIME == 3'h0);

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            all_low_q <= 1'b0;
            xfer_pend <= 1'b0;
        end
        else
        begin
            all_low_q <= all_low;
            if (frm_start)
                xfer_pend <= 1'b0;
            if (!I_MASTER_MODE && all_low && !all_low_q)
                xfer_pend <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            O_PIXEL_RESET <= 1'b0;
            O_DUAL_SLOPE_RESET <= 1'b0;
            O_TRIPLE_SLOPE_RESET <= 1'b0;
            O_FRAME_TRANSFER <= 1'b0;
            O_PIXEL_SAMPLE <= 1'b0;
            O_INT_TIME <= 3'h0;
            O_INT_TIME_OE <= 3'h0;
            O_FRAME_OVERHEAD <= 1'b0;
            O_ROW_OVERHEAD <= 1'b0;
        end
        else
        begin
            O_PIXEL_RESET <= pix_rst && !I_NDR;
            O_DUAL_SLOPE_RESET <= !I_NDR && (I_MASTER_MODE ? pact[PI_DUAL]
                                  : (I_INT_TIME[0] && !I_INT_TIME[1]));
            O_TRIPLE_SLOPE_RESET <= !I_NDR && (I_MASTER_MODE ? pact[PI_TRIPLE]
                                    : (I_INT_TIME[0] && !I_INT_TIME[2]));
            O_FRAME_TRANSFER <= pact[PI_XFER];
            O_PIXEL_SAMPLE <= pact[PI_SAMPLE];
            O_INT_TIME <= I_MASTER_MODE ? win : 3'h0;
            O_INT_TIME_OE <= {3{I_MASTER_MODE}};
            O_FRAME_OVERHEAD <= (state == ST_FRM);
            O_ROW_OVERHEAD <= (state == ST_ROW);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [9:0] lv_w;
    logic [7:0] xfer_w;
    logic [7:0] smp_w;

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            lv_w <= 10'h000;
            xfer_w <= 8'h00;
            smp_w <= 8'h00;
        end
        else
        begin
            lv_w <= O_LINE_VALID ? lv_w + 10'h001 : 10'h000;
            xfer_w <= O_FRAME_TRANSFER ? xfer_w + 8'h01 : 8'h00;
            smp_w <= O_PIXEL_SAMPLE ? smp_w + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);

    core_div_a: assert property (core_tick |=> !core_tick [*3] ##1 core_tick)
        else $error("core tick period is not four clocks");
    line_kern_a: assert property (O_LINE_VALID == (state == ST_KERN))
        else $error("line valid out of kernel phase");
    line_len_a: assert property ($fell(O_LINE_VALID) |-> lv_w == LINE_CLOCKS)
        else $error("line valid length wrong");
    cnt_load_a: assert property (frm_end |=> line_cnt == (I_SUBSAMPLE ? LINE_START_SUB
                                                          : LINE_START))
        else $error("line counter not reloaded after overhead");
    xfer_len_a: assert property ($fell(O_FRAME_TRANSFER) |->
        xfer_w == irs_pulse_len(I_OVERHEAD_GRANULARITY, RESET_EXTRA))
        else $error("frame transfer pulse length wrong");
    sample_len_a: assert property ($fell(O_PIXEL_SAMPLE) |->
        smp_w == irs_pulse_len(I_OVERHEAD_GRANULARITY, SAMPLE_EXTRA))
        else $error("pixel sample pulse length wrong");
    fv_drop_a: assert property ($fell(O_FRAME_VALID) |->
        (lines_read == FRAME_LINES) || (state == ST_FRM))
        else $error("frame valid fell at wrong line");
    ndr_mask_a: assert property (I_NDR && $past(I_NDR) |->
        !O_PIXEL_RESET && !O_DUAL_SLOPE_RESET && !O_TRIPLE_SLOPE_RESET)
        else $error("reset pulse under non-destructive read");
    slave_oe_a: assert property (!I_MASTER_MODE |=> O_INT_TIME_OE == 3'h0)
        else $error("integration pins driven in slave mode");
    win_start_a: assert property (I_MASTER_MODE && $past(I_MASTER_MODE) && $rose(O_INT_TIME[0])
        |-> $past(pix_rst, 2) && !$past(pix_rst))
        else $error("window 1 rose without reset release");
    slave_xfer_a: assert property (!I_MASTER_MODE && all_low && !all_low_q && state != ST_FRM
        |-> ##[1:1000] state == ST_FRM)
        else $error("slave frame transfer not started");

    frm_c: cover property (frm_end);
    lines_c: cover property ($fell(O_FRAME_VALID) && lines_read == FRAME_LINES);
    dual_c: cover property ($fell(O_DUAL_SLOPE_RESET) && I_MASTER_MODE);
    slave_c: cover property (frm_start && !I_MASTER_MODE);

endmodule : irs_sequencer
`default_nettype wire

/* File: tb/irs_pin_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module irs_pin_ctrl
    import irs_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Control from the bench
    input wire logic i_drive,
    input wire logic [2:0] i_cmd,
    // Active-low integration pins
    output logic [2:0] o_pins,
    output logic o_pins_oe
);
    // ------------------------------------------------------------
    // Pin patterns: 1 hold reset, 2/3 partial resets, 4 end integration
    // ------------------------------------------------------------
    initial o_pins = 3'h7;
    initial o_pins_oe = 1'b0;

    // Pulses are driven whatever the suppress setting is
    always_ff @(posedge i_clk)
    begin
        case (i_cmd)
            3'h1: o_pins <= 3'h6;
            3'h2: o_pins <= 3'h5;
            3'h3: o_pins <= 3'h3;
            3'h4: o_pins <= 3'h0;
            default: o_pins <= 3'h7;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        o_pins_oe <= i_drive;
    end
endmodule : irs_pin_ctrl
`default_nettype wire

/* File: tb/irs_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[ERR] %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module irs_sequencer_tb
    import irs_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int CORE = 0, FV = 1, LV = 2, FRMO = 3, ROWO = 4, PR = 5, DUAL = 6;
    localparam int TRIP = 7, XFER = 8, PS = 9, IT0 = 10, IT1 = 11;
    logic ref_clk, srst, master, sub, ndr;
    logic [1:0] overhead_granularity;
    logic [11:0] res_len, sec_line, thr_line, xfer_line;
    logic [2:0] cmd, int_out, int_oe, ctl_pins, pins;
    logic ctl_oe, core, fv, lv, frmo, rowo, pr, dual, trip, xfer, ps;
    logic [11:0] obs;
    int fails = 0;
    int samples_checked = 0;
    int reset_seen = 0;

    assign obs = {int_out[1:0], ps, xfer, trip, dual, pr, rowo, frmo, lv, fv, core};
    // Pins pulled up when nobody drives them
    assign pins = (int_oe & int_out) | (~int_oe & (ctl_oe ? ctl_pins : 3'h7));

    irs_sequencer dut (.I_REF_CLK(ref_clk), .I_SRST(srst), .I_MASTER_MODE(master),
        .I_SUBSAMPLE(sub), .I_NDR(ndr), .I_DUAL_SLOPE_EN(1'b1), .I_TRIPLE_SLOPE_EN(1'b1),
        .I_OVERHEAD_GRANULARITY(overhead_granularity), .I_RESET_LENGTH_LINES(res_len),
        .I_SECOND_RESET_LINE(sec_line), .I_THIRD_RESET_LINE(thr_line),
        .I_TRANSFER_LINE(xfer_line), .I_INT_TIME(pins), .O_INT_TIME(int_out),
        .O_INT_TIME_OE(int_oe), .O_CORE_CLK(core), .O_FRAME_VALID(fv), .O_LINE_VALID(lv),
        .O_FRAME_OVERHEAD(frmo), .O_ROW_OVERHEAD(rowo), .O_PIXEL_RESET(pr),
        .O_DUAL_SLOPE_RESET(dual), .O_TRIPLE_SLOPE_RESET(trip), .O_FRAME_TRANSFER(xfer),
        .O_PIXEL_SAMPLE(ps));

    irs_pin_ctrl ctl (.i_clk(ref_clk), .i_drive(~master), .i_cmd(cmd), .o_pins(ctl_pins),
        .o_pins_oe(ctl_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if ((pr | dual | trip) === 1'b1)
            reset_seen++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wait_for(input int idx, input logic val, input int limit);
        int n;
        n = 0;
        samples_checked++;
        while (obs[idx] !== val && n < limit)
        begin
            step();
            n++;
        end
        if (obs[idx] !== val)
        begin
            fails++;
            $display("[ERR] output %0d expected %0h seen %0h", idx, val, obs[idx]);
        end
    endtask : wait_for

    task automatic high_len(input int idx, output int len);
        len = 0;
        while (obs[idx] === 1'b1 && len < 5000)
        begin
            step();
            len++;
        end
    endtask : high_len

    task automatic pulse_len(input int idx, output int len);
        wait_for(idx, 1'b1, 4000);
        high_len(idx, len);
    endtask : pulse_len

    task automatic count_lines(input int max_lines, output int lines);
        logic prev;
        int n;
        lines = 0;
        n = 0;
        prev = lv;
        while (xfer !== 1'b1 && lines < max_lines && n < 20000)
        begin
            step();
            n++;
            if (lv === 1'b1 && prev === 1'b0)
                lines++;
            prev = lv;
        end
    endtask : count_lines

    task automatic seq_reset;
        int a;
        srst = 1'b1;
        repeat (5) step();
        `CHK("outputs in reset", 12'h0, obs)
        srst = 1'b0;
        wait_for(CORE, 1'b1, 8);
        high_len(CORE, a);
        `CHK("core clock high", CORE_DIV / 2, a)
    endtask : seq_reset

    task automatic master_frame(input int g);
        int lines, a, b, c, d, e, u;
        u = PULSE_UNIT * (g + 1);
        overhead_granularity = 2'(g);
        seq_reset();
        `CHK("pin enables", 3'h7, int_oe)
        fork
            count_lines(8, lines);
            begin
                wait_for(PR, 1'b1, 8);
                wait_for(PR, 1'b0, 3000);
                wait_for(IT0, 1'b1, 3);
                pulse_len(DUAL, a);
                `CHK("dual reset length", CORE_DIV * (u + 1), a)
                wait_for(IT1, 1'b1, 3);
            end
            begin
                pulse_len(TRIP, b);
                `CHK("triple reset length", CORE_DIV * (u + 1), b)
            end
        join
        `CHK("lines to transfer", 3, lines)
        fork
            high_len(XFER, a);
            begin
                high_len(PS, b);
                wait_for(IT0, 1'b0, 3);
            end
            begin
                high_len(FRMO, c);
                high_len(ROWO, d);
            end
            // Line valid rises one clock before the row overhead output falls
            begin
                wait_for(LV, 1'b1, 1000);
                high_len(LV, e);
            end
        join
        `CHK("transfer length", CORE_DIV * (u + 1), a)
        `CHK("sample length", CORE_DIV * (u + 2), b)
        `CHK("frame overhead length", CORE_DIV * (u + 2), c)
        `CHK("row overhead length", CORE_DIV * ROW_UNIT * (g + 1), d)
        `CHK("line valid length", int'(LINE_CLOCKS), e)
        `CHK("frame valid in readout", 1'b1, fv)
        count_lines(8, lines);
        `CHK("lines of second frame", 2, lines)
        `CHK("frame valid at transfer", 1'b0, fv)
    endtask : master_frame

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        int lines;
        srst = 1'b1;
        master = 1'b1;
        sub = 1'b0;
        ndr = 1'b0;
        overhead_granularity = 2'h0;
        cmd = 3'h0;
        res_len = 12'h002;
        sec_line = 12'h003;
        thr_line = 12'h003;
        xfer_line = 12'h004;
        for (int g = 0; g < 4; g++)
            master_frame(g);
        overhead_granularity = 2'h0;
        ndr = 1'b1;
        seq_reset();
        reset_seen = 0;
        count_lines(8, lines);
        `CHK("lines with suppressed resets", 3, lines)
        `CHK("reset pulses seen", 0, reset_seen)
        ndr = 1'b0;
        sub = 1'b1;
        res_len = 12'h004;
        sec_line = 12'h004;
        thr_line = 12'h004;
        xfer_line = 12'h006;
        seq_reset();
        count_lines(8, lines);
        `CHK("subsampled lines", 2, lines)
        sub = 1'b0;
        xfer_line = 12'h004;
        master = 1'b0;
        seq_reset();
        `CHK("slave pin enables", 3'h0, int_oe)
        cmd = 3'h1;
        wait_for(PR, 1'b1, 8);
        cmd = 3'h0;
        wait_for(PR, 1'b0, 8);
        cmd = 3'h2;
        wait_for(DUAL, 1'b1, 8);
        cmd = 3'h3;
        wait_for(TRIP, 1'b1, 8);
        cmd = 3'h0;
        count_lines(4, lines);
        `CHK("slave lines", 4, lines)
        `CHK("slave windows", 3'h0, int_out)
        cmd = 3'h4;
        wait_for(XFER, 1'b1, 1000);
        cmd = 3'h0;
        end_of_test();
    end

    initial
    begin
        #600000;
        fails++;
        $display("[ERR] run time expected under 60000 cycles seen more");
        end_of_test();
    end
endmodule : irs_sequencer_tb
`undef CHK
`default_nettype wire
